// >>> mff_pkg.sv
// package: constants, types and decode helpers of the mac accelerator
package mff_pkg;
	// ==========================================================
	// timing
	localparam int unsigned CLK_HZ    = 25_000_000;
	localparam int unsigned SYMBOL_NS = 16000;
	localparam int unsigned SYM_CYC   =
		(SYMBOL_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned TR10_NS   = 16000;
	localparam logic [5:0]  TR10_SYM  =
		6'((TR10_NS + SYMBOL_NS - 1) / SYMBOL_NS);
	localparam logic [5:0]  ACK_STD_SYM   = 6'h0C;
	localparam logic [5:0]  ACK_SHORT_SYM = 6'h02;
	localparam logic [5:0]  SLOT_PREP_SYM = 6'h06;
	localparam logic [5:0]  ACK_TMO_SYM   = 6'h36;
	// ==========================================================
	// codes
	localparam logic [2:0] RES_SUCCESS   = 3'h0;
	localparam logic [2:0] RES_PENDING   = 3'h1;
	localparam logic [2:0] RES_WAIT_ACK  = 3'h2;
	localparam logic [2:0] RES_CHAN_FAIL = 3'h3;
	localparam logic [2:0] RES_NO_ACK    = 3'h5;
	localparam logic [2:0] RES_INVALID   = 3'h7;
	localparam logic [4:0] RD_OFF        = 5'h08;
	localparam logic [4:0] RD_RX_BUSY    = 5'h11;
	localparam logic [4:0] RD_TX_BUSY    = 5'h12;
	localparam logic [4:0] RD_RX_IDLE    = 5'h16;
	localparam logic [4:0] RD_TX_IDLE    = 5'h19;
	localparam logic [1:0] MODE_RX       = 2'h1;
	localparam logic [1:0] MODE_TX       = 2'h2;
	localparam logic [2:0] FT_BEACON     = 3'h0;
	localparam logic [2:0] FT_DATA       = 3'h1;
	localparam logic [2:0] FT_ACK        = 3'h2;
	localparam logic [2:0] FT_CMD        = 3'h3;
	localparam logic [2:0] CSMA_NONE     = 3'h7;
	localparam int unsigned ACK_REQ_BIT  = 5;
	localparam logic [15:0] BCAST        = 16'hFFFF;
	localparam logic [63:0] EXT_RST      = 64'hFFFF_FFFF_FFFF_FFFF;
	// ==========================================================
	// register map
	localparam logic [7:0]  OFS_CTRL   = 8'h00;
	localparam logic [7:0]  OFS_PAN    = 8'h04;
	localparam logic [7:0]  OFS_SHORT  = 8'h08;
	localparam logic [7:0]  OFS_EXT_LO = 8'h0C;
	localparam logic [7:0]  OFS_EXT_HI = 8'h10;
	localparam logic [7:0]  OFS_STATUS = 8'h14;
	localparam logic [7:0]  OFS_CMD    = 8'h18;
	localparam logic [2:0]  HSIZE_WORD = 3'h2;
	localparam logic [16:0] CTRL_RST   = 17'h1_3880;
	// ==========================================================
	// types
	typedef struct packed {
		logic       ami_en;
		logic [3:0] max_frame;
		logic [2:0] max_csma;
		logic [1:0] fvn_policy;
		logic       accept_res;
		logic       filter_res;
		logic       coord;
		logic       short_ack;
		logic       slotted;
		logic [1:0] mode;
	} mff_cfg_t;
	typedef struct packed {
		logic [2:0]  ftype;
		logic [1:0]  ver;
		logic        ack_req;
		logic        pending;
		logic [1:0]  dmode;
		logic [1:0]  smode;
		logic [15:0] dpan;
		logic [63:0] daddr;
		logic [15:0] span;
		logic        fcs_ok;
	} mff_rx_hdr_t;
	function automatic logic ft_reserved(input logic [2:0] ft);
		return ft[2];
	endfunction : ft_reserved
endpackage : mff_pkg

// >>> mff_filter.sv
// third-level receive address filter
module mff_filter
	import mff_pkg::*;
(
	input  wire mff_cfg_t    cfg_i,
	input  wire logic [15:0] pan_i,
	input  wire logic [15:0] short_i,
	input  wire logic [63:0] ext_i,
	input  wire mff_rx_hdr_t hdr_i,
	output logic             accept_o,
	output logic             ami_o
);
	logic res;
	logic ver_ok;
	logic dst_ok;
	logic bcn_ok;
	logic src_ok;
	logic pass;
	always_comb
	begin
		res = ft_reserved(hdr_i.ftype);
		case (cfg_i.fvn_policy)
			2'h0: ver_ok = hdr_i.ver == 2'h0; // R2
			2'h1: ver_ok = hdr_i.ver <= 2'h1; // R2
			2'h2: ver_ok = hdr_i.ver <= 2'h2; // R2
			default: ver_ok = 1'b1;
		endcase
		case (hdr_i.dmode)
			2'h2: dst_ok = (hdr_i.daddr[15:0] == short_i) ||
				(hdr_i.daddr[15:0] == BCAST); // R4
			2'h3: dst_ok = hdr_i.daddr == ext_i; // R4
			default: dst_ok = 1'b1;
		endcase
		if (hdr_i.dmode[1])
			dst_ok = dst_ok &&
				(hdr_i.dpan == pan_i || hdr_i.dpan == BCAST); // R3
		bcn_ok = (hdr_i.ftype != FT_BEACON) ||
			(hdr_i.span == pan_i) || (pan_i == BCAST); // R5
		src_ok = hdr_i.dmode[1] || (hdr_i.ftype == FT_BEACON) ||
			((hdr_i.smode != 2'h0) && cfg_i.coord &&
			(hdr_i.span == pan_i)); // R6 R23
		pass = ver_ok && dst_ok && bcn_ok && src_ok &&
			((pan_i != BCAST) || (short_i != BCAST) ||
			(ext_i != EXT_RST)); // R8
		if (hdr_i.ftype == FT_ACK)
			accept_o = 1'b0; // R7
		else if (res && !cfg_i.accept_res)
			accept_o = 1'b0; // R1 R24
		else if (res && !cfg_i.filter_res)
			accept_o = 1'b1; // R1
		else
			accept_o = pass;
		ami_o = accept_o && !(res && !cfg_i.filter_res) &&
			!((hdr_i.dmode <= 2'h1) && (hdr_i.smode == 2'h0)); // R9
	end
endmodule : mff_filter

// >>> mff_sym_timer.sv
// symbol period countdown timer, restarted in phase on each load
module mff_sym_timer
	import mff_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       load_i,
	input  wire logic [5:0] sym_i,
	output logic            expire_o
);
	localparam logic [8:0] PRE_LAST = 9'(SYM_CYC - 1);
	logic [8:0] pre_q;
	logic [5:0] cnt_q;
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			pre_q <= '0;
			cnt_q <= '0;
		end
		else if (load_i)
		begin
			pre_q <= '0;
			cnt_q <= sym_i;
		end
		else if (cnt_q != 6'h0)
		begin
			if (pre_q == PRE_LAST)
			begin
				pre_q <= '0;
				cnt_q <= cnt_q - 6'h1; // R25
			end
			else
				pre_q <= pre_q + 9'h1;
		end
	end
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			expire_o <= 1'b0;
		else
			expire_o <= !load_i && cnt_q == 6'h1 && pre_q == PRE_LAST;
	end
endmodule : mff_sym_timer

// >>> mff_mac_accel.sv
// mac accelerator: frame filter, auto acknowledge, auto retry transmit
// Contract
// R1 - reserved frame types rejected unless reserved handling configured
// R2 - reserved frame versions rejected, relaxed by version policy field
// R3 - destination pan must match own pan or broadcast
// R4 - short destination matches own or broadcast, else extended matches
// R5 - beacon source pan must match own, any if own is all ones
// R6 - source-only data or command accepted only as coordinator, pan match
// R7 - acknowledgement frames are never accepted
// R8 - no configured address means no frame accepted; code still passes reserved frames if accept_res set, filter_res clear
// R9 - no address match irq for dest mode 0/1 with source mode 0
// R10 - passing frame raises address match irq when unmasked
// R11 - slotted: pending ack waits trigger rising edge, sent 16 us after
// R12 - slotted: 6 symbols after frame end result shows wait-for-ack
// R13 - unslotted ack after 12 symbols, or 2 with short turnaround
// R14 - transmit start runs csma then sends frame on idle channel
// R15 - busy beyond max backoff attempts: abort, frame end irq, code 3
// R16 - ack request bit 5 of first octet decides waiting for ack
// R17 - ack wait discards other frames, code 0 or 1 by pending bit
// R18 - no ack in 54 symbols retries; resends exceeded gives code 5
// R19 - no ack requested: frame end irq and success after transmit
// R20 - entering auto retry mode sets result to 7
// R21 - backoff setting 7: no csma, one attempt only
// R22 - readout busy during transaction, idle state when it ends
// R23 - configuration bit tells filter whether device is coordinator
// R24 - reserved reception disabled discards reserved frames
// R25 - symbol timers derive from a 16 us tick of the clock
module mff_mac_accel
	import mff_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic             hreadyout_o,
	output logic             hresp_o,
	output logic [31:0]      hrdata_o,
	input  wire logic        sleep_tx_trigger_pin_i,
	input  wire logic        rx_end_i,
	input  wire mff_rx_hdr_t rx_hdr_i,
	input  wire logic        csma_done_i,
	input  wire logic        csma_idle_i,
	input  wire logic        tx_done_i,
	input  wire logic [7:0]  tx_fcf_i,
	output logic             csma_start_o,
	output logic             tx_start_o,
	output logic             ack_tx_start_o,
	output logic             address_match_irq_o,
	output logic             frame_end_irq_o,
	output logic [4:0]       radio_state_readout_o
);
	typedef enum logic [7:0] {
		ST_IDLE    = 8'h01,
		ST_RX_DLY  = 8'h02,
		ST_RX_PREP = 8'h04,
		ST_RX_HOLD = 8'h08,
		ST_RX_TR   = 8'h10,
		ST_CSMA    = 8'h20,
		ST_TX      = 8'h40,
		ST_ACK     = 8'h80
	} mff_state_t;
	mff_state_t  state_q;
	mff_cfg_t    cfg_q;
	logic [15:0] pan_q;
	logic [15:0] short_q;
	logic [63:0] ext_q;
	logic [1:0]  mode_prev_q;
	logic        wr_q;
	logic [7:0]  addr_q;
	logic        pin_s1_q;
	logic        pin_s2_q;
	logic        pin_s3_q;
	logic        pin_rise;
	logic        cmd_start;
	logic        enter_tx;
	logic        accept;
	logic        ami;
	logic        ack_type;
	logic        single;
	logic        expire;
	logic        tmr_load_q;
	logic [5:0]  tmr_sym_q;
	logic [2:0]  csma_cnt_q;
	logic [4:0]  frame_cnt_q;
	logic [2:0]  result_q;
	logic        addr_ph;
	// ==========================================================
	// ahb-lite slave, zero wait states
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign addr_ph     = hsel_i && htrans_i[1] && hready_i &&
		hsize_i == HSIZE_WORD;
	assign cmd_start   = wr_q && addr_q == OFS_CMD && hwdata_i[0];
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			wr_q   <= 1'b0;
			addr_q <= '0;
		end
		else
		begin
			wr_q <= addr_ph && hwrite_i;
			if (addr_ph)
				addr_q <= {haddr_i[7:2], 2'b00};
		end
	end
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			hrdata_o <= '0;
		else if (addr_ph && !hwrite_i)
		begin
			case ({haddr_i[7:2], 2'b00})
				OFS_CTRL:   hrdata_o <= {15'h0, cfg_q};
				OFS_PAN:    hrdata_o <= {16'h0, pan_q};
				OFS_SHORT:  hrdata_o <= {16'h0, short_q};
				OFS_EXT_LO: hrdata_o <= ext_q[31:0];
				OFS_EXT_HI: hrdata_o <= ext_q[63:32];
				OFS_STATUS: hrdata_o <= {24'h0, result_q,
					radio_state_readout_o};
				default:    hrdata_o <= '0;
			endcase
		end
	end
	// ==========================================================
	// configuration registers
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			cfg_q   <= mff_cfg_t'(CTRL_RST);
			pan_q   <= BCAST;
			short_q <= BCAST;
			ext_q   <= EXT_RST;
		end
		else if (wr_q)
		begin
			case (addr_q)
				OFS_CTRL:   cfg_q <= mff_cfg_t'(hwdata_i[16:0]);
				OFS_PAN:    pan_q <= hwdata_i[15:0];
				OFS_SHORT:  short_q <= hwdata_i[15:0];
				OFS_EXT_LO: ext_q[31:0] <= hwdata_i;
				OFS_EXT_HI: ext_q[63:32] <= hwdata_i;
				default:    pan_q <= pan_q;
			endcase
		end
	end
	// ==========================================================
	// trigger pin synchroniser and edge
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			pin_s1_q    <= 1'b0;
			pin_s2_q    <= 1'b0;
			pin_s3_q    <= 1'b0;
			mode_prev_q <= 2'h0;
		end
		else
		begin
			pin_s1_q    <= sleep_tx_trigger_pin_i;
			pin_s2_q    <= pin_s1_q;
			pin_s3_q    <= pin_s2_q;
			mode_prev_q <= cfg_q.mode;
		end
	end
	assign pin_rise = pin_s2_q && !pin_s3_q;
	assign enter_tx = cfg_q.mode == MODE_TX && mode_prev_q != MODE_TX;
	assign single   = cfg_q.max_csma == CSMA_NONE;
	assign ack_type = rx_hdr_i.ftype == FT_DATA ||
		rx_hdr_i.ftype == FT_CMD ||
		(ft_reserved(rx_hdr_i.ftype) && cfg_q.filter_res);
	mff_filter u_filter (
		.cfg_i    (cfg_q),
		.pan_i    (pan_q),
		.short_i  (short_q),
		.ext_i    (ext_q),
		.hdr_i    (rx_hdr_i),
		.accept_o (accept),
		.ami_o    (ami)
	);
	mff_sym_timer u_timer (
		.clk_i    (clk_i),
		.rst_n_i  (rst_n_i),
		.load_i   (tmr_load_q),
		.sym_i    (tmr_sym_q),
		.expire_o (expire)
	);
	// ==========================================================
	// transaction state machine
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			state_q             <= ST_IDLE;
			csma_cnt_q          <= '0;
			frame_cnt_q         <= '0;
			result_q            <= RES_INVALID;
			tmr_load_q          <= 1'b0;
			tmr_sym_q           <= '0;
			csma_start_o        <= 1'b0;
			tx_start_o          <= 1'b0;
			ack_tx_start_o      <= 1'b0;
			address_match_irq_o <= 1'b0;
			frame_end_irq_o     <= 1'b0;
		end
		else
		begin
			tmr_load_q          <= 1'b0;
			csma_start_o        <= 1'b0;
			tx_start_o          <= 1'b0;
			ack_tx_start_o      <= 1'b0;
			address_match_irq_o <= 1'b0;
			frame_end_irq_o     <= 1'b0;
			if (enter_tx)
				result_q <= RES_INVALID; // R20
			case (state_q)
				ST_IDLE:
				begin
					if (cfg_q.mode == MODE_RX && rx_end_i && accept)
					begin
						address_match_irq_o <= ami && cfg_q.ami_en; // R10
						frame_end_irq_o     <= rx_hdr_i.fcs_ok;
						if (rx_hdr_i.fcs_ok && rx_hdr_i.ack_req && ack_type)
						begin
							tmr_load_q <= 1'b1;
							if (cfg_q.slotted)
							begin
								tmr_sym_q <= SLOT_PREP_SYM; // R12
								state_q   <= ST_RX_PREP;
							end
							else
							begin
								tmr_sym_q <= cfg_q.short_ack ?
									ACK_SHORT_SYM : ACK_STD_SYM; // R13
								state_q   <= ST_RX_DLY;
							end
						end
					end
					else if (cfg_q.mode == MODE_TX && (cmd_start || pin_rise))
					begin
						frame_cnt_q <= '0; // R14
						if (single)
						begin
							tx_start_o <= 1'b1; // R21
							state_q    <= ST_TX;
						end
						else
						begin
							csma_cnt_q   <= '0;
							csma_start_o <= 1'b1; // R14
							state_q      <= ST_CSMA;
						end
					end
				end
				ST_RX_DLY:
				begin
					if (expire)
					begin
						ack_tx_start_o <= 1'b1; // R13
						state_q        <= ST_IDLE;
					end
				end
				ST_RX_PREP:
				begin
					if (expire)
					begin
						result_q <= RES_WAIT_ACK; // R12
						state_q  <= ST_RX_HOLD;
					end
				end
				ST_RX_HOLD:
				begin
					if (pin_rise)
					begin
						tmr_load_q <= 1'b1; // R11
						tmr_sym_q  <= TR10_SYM;
						state_q    <= ST_RX_TR;
					end
				end
				ST_RX_TR:
				begin
					if (expire)
					begin
						ack_tx_start_o <= 1'b1; // R11
						state_q        <= ST_IDLE;
					end
				end
				ST_CSMA:
				begin
					if (csma_done_i && csma_idle_i)
					begin
						tx_start_o <= 1'b1; // R14
						state_q    <= ST_TX;
					end
					else if (csma_done_i && csma_cnt_q >= cfg_q.max_csma)
					begin
						result_q        <= RES_CHAN_FAIL; // R15
						frame_end_irq_o <= 1'b1;
						state_q         <= ST_IDLE;
					end
					else if (csma_done_i)
					begin
						csma_cnt_q   <= csma_cnt_q + 3'h1; // R15
						csma_start_o <= 1'b1;
					end
				end
				ST_TX:
				begin
					if (tx_done_i)
					begin
						frame_cnt_q <= frame_cnt_q + 5'h1;
						if (tx_fcf_i[ACK_REQ_BIT])
						begin
							tmr_load_q <= 1'b1; // R16
							tmr_sym_q  <= ACK_TMO_SYM;
							state_q    <= ST_ACK;
						end
						else
						begin
							result_q        <= RES_SUCCESS; // R19
							frame_end_irq_o <= 1'b1;
							state_q         <= ST_IDLE;
						end
					end
				end
				ST_ACK:
				begin
					if (rx_end_i && rx_hdr_i.ftype == FT_ACK &&
						rx_hdr_i.fcs_ok)
					begin
						result_q <= rx_hdr_i.pending ?
							RES_PENDING : RES_SUCCESS; // R17
						frame_end_irq_o <= 1'b1;
						state_q         <= ST_IDLE;
					end
					else if (expire &&
						(single || frame_cnt_q > {1'b0, cfg_q.max_frame}))
					begin
						result_q        <= RES_NO_ACK; // R18 R21
						frame_end_irq_o <= 1'b1;
						state_q         <= ST_IDLE;
					end
					else if (expire)
					begin
						csma_cnt_q   <= '0; // R18
						csma_start_o <= 1'b1;
						state_q      <= ST_CSMA;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end
	// ==========================================================
	// state readout
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			radio_state_readout_o <= RD_OFF;
		else
		begin
			case (cfg_q.mode)
				MODE_RX: radio_state_readout_o <= (state_q inside
					{ST_RX_DLY, ST_RX_PREP, ST_RX_HOLD, ST_RX_TR}) ?
					RD_RX_BUSY : RD_RX_IDLE;
				MODE_TX: radio_state_readout_o <= (state_q inside
					{ST_CSMA, ST_TX, ST_ACK}) ?
					RD_TX_BUSY : RD_TX_IDLE; // R22
				default: radio_state_readout_o <= RD_OFF;
			endcase
		end
	end
	// ==========================================================
	// assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_pin_go;
		state_q == ST_RX_HOLD && pin_rise;
	endsequence
	a_enter_result: assert property (enter_tx && state_q == ST_IDLE
		|=> result_q == RES_INVALID) else $error("result not 7"); // R20
	a_busy_show: assert property (cfg_q.mode == MODE_TX &&
		state_q inside {ST_TX, ST_ACK} |=>
		radio_state_readout_o == RD_TX_BUSY)
		else $error("readout not busy"); // R22
	a_chan_fail: assert property (state_q == ST_CSMA && csma_done_i &&
		!csma_idle_i && csma_cnt_q >= cfg_q.max_csma |=>
		result_q == RES_CHAN_FAIL && frame_end_irq_o)
		else $error("no channel failure"); // R15
	a_no_csma: assert property (state_q == ST_IDLE &&
		cfg_q.mode == MODE_TX && cmd_start && single |=>
		tx_start_o && !csma_start_o) else $error("csma ran"); // R21
	a_ack_code: assert property (state_q == ST_ACK && rx_end_i &&
		rx_hdr_i.ftype == FT_ACK && rx_hdr_i.fcs_ok |=>
		frame_end_irq_o && result_q == {2'b00, $past(rx_hdr_i.pending)})
		else $error("bad ack code"); // R17
	a_no_ack_req: assert property (state_q == ST_TX && tx_done_i &&
		!tx_fcf_i[ACK_REQ_BIT] |=> result_q == RES_SUCCESS &&
		frame_end_irq_o) else $error("no success"); // R19
	a_ack_reject: assert property (state_q == ST_IDLE && rx_end_i &&
		rx_hdr_i.ftype == FT_ACK |=> !frame_end_irq_o &&
		!address_match_irq_o) else $error("ack accepted"); // R7
	a_slot_hold: assert property (state_q == ST_RX_HOLD && !pin_rise
		|=> state_q == ST_RX_HOLD && !ack_tx_start_o)
		else $error("ack left early"); // R11
	a_slot_delay: assert property (s_pin_go |-> ##[402:404]
		ack_tx_start_o) else $error("ack not 16 us later"); // R11
endmodule : mff_mac_accel

// >>> mff_radio_model.sv
// radio side model: channel access and frame transmit responses
module mff_radio_model
	import mff_pkg::*;
#(
	parameter int DLY = 20
)
(
	input  wire logic  clk_i,
	input  wire logic  csma_start_i,
	input  wire logic  tx_start_i,
	input  wire logic  busy_i,
	input  wire logic  ack_req_i,
	output logic       csma_done_o,
	output logic       csma_idle_o,
	output logic       tx_done_o,
	output logic [7:0] tx_fcf_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int cc;
	int tc;
	initial
	begin
		cc = 0;
		tc = 0;
		csma_done_o = 1'b0;
		csma_idle_o = 1'b0;
		tx_done_o = 1'b0;
		tx_fcf_o = 8'h00;
	end
	// ==========================================================
	// channel access and transmit
	always @(posedge clk_i)
	begin
		csma_done_o <= 1'b0;
		tx_done_o <= 1'b0;
		// qualifiers toggle outside their pulse, never a stale value
		csma_idle_o <= ~csma_idle_o;
		tx_fcf_o <= ~tx_fcf_o;
		if (csma_start_i) cc <= DLY;
		else if (cc > 0)
		begin
			cc <= cc - 1;
			if (cc == 1)
			begin
				csma_done_o <= 1'b1;
				csma_idle_o <= ~busy_i;
			end
		end
		if (tx_start_i) tc <= DLY;
		else if (tc > 0)
		begin
			tc <= tc - 1;
			if (tc == 1)
			begin
				tx_done_o <= 1'b1;
				tx_fcf_o <= {2'h0, ack_req_i, 5'h01};
			end
		end
	end
endmodule : mff_radio_model

// >>> mff_mac_accel_bench.sv
// testbench of the mac accelerator
module mff_mac_accel_bench
	import mff_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, rst_n_i = 0, hsel_i = 0, hwrite_i = 0, pin = 0;
	logic rx_end_i = 0, busy = 0, ack_req = 0;
	logic [31:0] haddr_i = '0, hwdata_i = '0, hrdata_o, r;
	logic [1:0]  htrans_i = '0;
	logic [2:0]  hsize_i = '0;
	mff_rx_hdr_t rx_hdr_i = '0;
	logic hreadyout_o, hresp_o, csma_start_o, tx_start_o, ack_tx_start_o;
	logic address_match_irq_o, frame_end_irq_o;
	logic csma_done_i, csma_idle_i, tx_done_i;
	logic [7:0]  tx_fcf_i;
	logic [4:0]  radio_state_readout_o;
	int n_fail = 0, samples_checked = 0, n;
	int cnt[5] = '{default: 0};
	int c0[5];
	mff_mac_accel uut (.clk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i,
		.hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o),
		.hreadyout_o, .hresp_o, .hrdata_o, .sleep_tx_trigger_pin_i(pin),
		.rx_end_i, .rx_hdr_i, .csma_done_i, .csma_idle_i, .tx_done_i,
		.tx_fcf_i, .csma_start_o, .tx_start_o, .ack_tx_start_o,
		.address_match_irq_o, .frame_end_irq_o, .radio_state_readout_o);
	mff_radio_model radio (.clk_i, .csma_start_i(csma_start_o),
		.tx_start_i(tx_start_o), .busy_i(busy), .ack_req_i(ack_req),
		.csma_done_o(csma_done_i), .csma_idle_o(csma_idle_i),
		.tx_done_o(tx_done_i), .tx_fcf_o(tx_fcf_i));
	always #20 clk_i = ~clk_i;
	// ==========================================================
	// helpers
	function automatic logic sig(input int w);
		case (w)
			0: return frame_end_irq_o;
			1: return ack_tx_start_o;
			2: return address_match_irq_o;
			3: return csma_start_o;
			4: return tx_start_o;
			default: return hreadyout_o;
		endcase
	endfunction : sig
	always @(posedge clk_i)
		for (int i = 0; i < 5; i++)
			if (sig(i) === 1'b1)
				cnt[i] <= cnt[i] + 1;
	function automatic logic [31:0] dl(input int i);
		return 32'(cnt[i] - c0[i]);
	endfunction : dl
	function automatic mff_rx_hdr_t hd(input logic [2:0] ft,
		input logic [1:0] v, input logic [15:0] dp, input logic [15:0] da,
		input logic ar, input logic pd);
		return '{ft, v, ar, pd, 2'h2, 2'h2, dp, {48'h0, da}, 16'h1234, 1'b1};
	endfunction : hd
	task give_verdict();
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		samples_checked++;
		if (seen !== ex)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, ex, seen);
		end
	endtask : chk
	task wt(input int w, input int lim, output int k);
		k = 0;
		do
		begin
			@(posedge clk_i);
			k++;
		end
		while (sig(w) !== 1'b1 && k < lim);
		if (sig(w) !== 1'b1)
		begin
			n_fail++;
			give_verdict();
		end
	endtask : wt
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		int k;
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		haddr_i <= {24'h0, a};
		hwrite_i <= w;
		hsize_i <= HSIZE_WORD;
		wt(5, 50, k);
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= d;
		wt(5, 50, k);
		rd = hrdata_o;
	endtask : ahb
	task st(input logic [2:0] res, input logic [4:0] rd);
		ahb(1'b0, OFS_STATUS, 32'h0, r);
		chk("status", r, {24'h0, res, rd});
	endtask : st
	task rx(input mff_rx_hdr_t h);
		rx_end_i <= 1'b1;
		rx_hdr_i <= h;
		@(posedge clk_i);
		rx_end_i <= 1'b0;
		rx_hdr_i <= mff_rx_hdr_t'(~h);
	endtask : rx
	// ==========================================================
	// scenarios
	task s_reset();
		ahb(1'b0, OFS_CTRL, 32'h0, r);
		chk("ctrl", r, {15'h0, CTRL_RST});
		st(RES_INVALID, RD_OFF);
		ahb(1'b0, 8'h1C, 32'h0, r);
		chk("unmapped", r, 32'h0);
		chk("hresp", {31'h0, hresp_o}, 32'h0);
	endtask : s_reset
	task s_filter();
		mff_rx_hdr_t fr[10];
		logic [9:0]  ok;
		logic [9:0]  okf;
		ahb(1'b1, OFS_CTRL, 32'h0001_3881, r);
		c0 = cnt;
		rx(hd(FT_DATA, 2'h1, 16'hFFFF, 16'hFFFF, 1'b0, 1'b0));
		repeat (4) @(posedge clk_i);
		chk("ami_noaddr", dl(2), 32'h0);
		ahb(1'b1, OFS_PAN, 32'h0000_1234, r);
		ahb(1'b1, OFS_SHORT, 32'h0000_0042, r);
		fr = '{hd(FT_DATA, 2'h1, 16'h1234, 16'h0042, 1'b0, 1'b0),
			hd(FT_ACK, 2'h1, 16'h1234, 16'h0042, 1'b0, 1'b0),
			hd(FT_DATA, 2'h1, 16'h5555, 16'h0042, 1'b0, 1'b0),
			hd(FT_CMD, 2'h1, 16'hFFFF, 16'hFFFF, 1'b0, 1'b0),
			hd(FT_DATA, 2'h1, 16'h1234, 16'h0043, 1'b0, 1'b0),
			hd(3'h4, 2'h1, 16'h1234, 16'h0042, 1'b0, 1'b0),
			hd(FT_DATA, 2'h2, 16'h1234, 16'h0042, 1'b0, 1'b0),
			hd(FT_BEACON, 2'h1, 16'h1234, 16'h0042, 1'b0, 1'b0),
			hd(FT_BEACON, 2'h1, 16'h1234, 16'h0042, 1'b0, 1'b0),
			hd(FT_DATA, 2'h1, 16'h1234, 16'h0042, 1'b0, 1'b0)};
		fr[5].dpan = 16'h5555;
		fr[7].dmode = 2'h0;
		fr[7].smode = 2'h0;
		fr[8].dmode = 2'h0;
		fr[8].smode = 2'h0;
		fr[8].span = 16'h5555;
		fr[9].dmode = 2'h0;
		ok = 10'b00_0000_1001;
		okf = 10'b00_1000_1001;
		for (int i = 0; i < 10; i++)
		begin
			c0 = cnt;
			rx(fr[i]);
			repeat (4) @(posedge clk_i);
			chk("ami", dl(2), {31'h0, ok[i]});
			chk("fend", dl(0), {31'h0, okf[i]});
		end
		ahb(1'b1, OFS_CTRL, 32'h0001_38D1, r);
		c0 = cnt;
		rx(fr[9]);
		repeat (4) @(posedge clk_i);
		chk("ami_coord", dl(2), 32'h1);
		chk("fend_coord", dl(0), 32'h1);
		c0 = cnt;
		rx(fr[5]);
		repeat (4) @(posedge clk_i);
		chk("ami_resv", dl(2), 32'h0);
		chk("fend_resv", dl(0), 32'h1);
	endtask : s_filter
	task s_ack();
		rx(hd(FT_DATA, 2'h1, 16'h1234, 16'h0042, 1'b1, 1'b0));
		wt(1, 6000, n);
		chk("ack_std", 32'(n >= 4795 && n <= 4815), 32'h1);
		repeat (50) @(posedge clk_i);
		ahb(1'b1, OFS_CTRL, 32'h0001_3889, r);
		rx(hd(FT_DATA, 2'h1, 16'h1234, 16'h0042, 1'b1, 1'b0));
		wt(1, 1200, n);
		chk("ack_short", 32'(n >= 795 && n <= 815), 32'h1);
		repeat (50) @(posedge clk_i);
		ahb(1'b1, OFS_CTRL, 32'h0001_3885, r);
		c0 = cnt;
		rx(hd(FT_CMD, 2'h1, 16'h1234, 16'h0042, 1'b1, 1'b0));
		repeat (2420) @(posedge clk_i);
		st(RES_WAIT_ACK, RD_RX_BUSY);
		chk("ack_held", dl(1), 32'h0);
		pin <= 1'b1;
		wt(1, 600, n);
		chk("ack_slot", 32'(n >= 400 && n <= 415), 32'h1);
		repeat (50) @(posedge clk_i);
	endtask : s_ack
	task txgo(input logic [31:0] ctl, input logic bz, input logic ar,
		input logic pn);
		ahb(1'b1, OFS_CTRL, ctl, r);
		busy <= bz;
		ack_req <= ar;
		pin <= 1'b0;
		repeat (4) @(posedge clk_i);
		c0 = cnt;
		if (pn)
			pin <= 1'b1;
		else
			ahb(1'b1, OFS_CMD, 32'h1, r);
	endtask : txgo
	task s_tx();
		ahb(1'b1, OFS_CTRL, 32'h0001_3882, r);
		repeat (2) @(posedge clk_i);
		st(RES_INVALID, RD_TX_IDLE);
		txgo(32'h0001_3882, 1'b0, 1'b0, 1'b0);
		wt(0, 500, n);
		st(RES_SUCCESS, RD_TX_IDLE);
		chk("csma", dl(3), 32'h1);
		chk("txs", dl(4), 32'h1);
		txgo(32'h0001_0402, 1'b1, 1'b0, 1'b1);
		wt(0, 2000, n);
		st(RES_CHAN_FAIL, RD_TX_IDLE);
		chk("csma_busy", dl(3), 32'h3);
		chk("txs_busy", dl(4), 32'h0);
		txgo(32'h0001_3882, 1'b0, 1'b1, 1'b0);
		wt(4, 500, n);
		repeat (60) @(posedge clk_i);
		ahb(1'b0, OFS_STATUS, 32'h0, r);
		chk("busy_state", {27'h0, r[4:0]}, {27'h0, RD_TX_BUSY});
		rx(hd(FT_DATA, 2'h1, 16'h1234, 16'h0042, 1'b0, 1'b1));
		repeat (4) @(posedge clk_i);
		chk("fend_other", dl(0), 32'h0);
		rx(hd(FT_ACK, 2'h1, 16'h1234, 16'h0042, 1'b0, 1'b1));
		wt(0, 10, n);
		st(RES_PENDING, RD_TX_IDLE);
		txgo(32'h0001_3E02, 1'b0, 1'b1, 1'b0);
		wt(0, 23000, n);
		chk("ack_tmo", 32'(n >= 21600 && n <= 21700), 32'h1);
		st(RES_NO_ACK, RD_TX_IDLE);
		chk("csma_none", dl(3), 32'h0);
		chk("txs_once", dl(4), 32'h1);
		txgo(32'h0001_1002, 1'b0, 1'b1, 1'b0);
		wt(0, 45000, n);
		st(RES_NO_ACK, RD_TX_IDLE);
		chk("csma_retry", dl(3), 32'h2);
		chk("txs_retry", dl(4), 32'h2);
	endtask : s_tx
	// ==========================================================
	// main sequence
	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		s_reset();
		s_filter();
		s_ack();
		s_tx();
		give_verdict();
	end
endmodule : mff_mac_accel_bench
